// File: rtl/adcc_pkg.sv
// Package of register map, field positions and timing constants for the converter control
package adcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_PINEN = 8'h08;
  localparam logic [7:0] OFS_PORTDIR = 8'h0c;
  localparam logic [7:0] OFS_PULLUP = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_INTCTL = 8'h18;
  // Control register 0 fields
  localparam int C0_CHLO = 0;
  localparam int C0_POWER_OFF = 5;
  localparam int C0_PENDING = 6;
  localparam int C0_START = 7;
  // Control register 1 fields
  localparam int C1_DIV = 0;
  localparam int C1_REF = 3;
  localparam int C1_CHHI = 4;
  // Interrupt control fields
  localparam int IC_GLOBAL = 0;
  localparam int IC_CONV = 1;
  localparam int IC_REQ = 2;
  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h60;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [11:0] PINEN_RST = 12'hfff;
  // Conversion geometry
  localparam int PIN_COUNT = 12;
  localparam int RES_BITS = 12;
  localparam int CONV_PERIODS = 16;
  localparam int CODE_COUNT = 4096;
  localparam logic [11:0] FULL_SCALE = 12'hfff;
  localparam logic [2:0] DIV_UNDEF = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Clock
  localparam int CLK_PERIOD_NS = 8;
  // Analog side request to the conversion core
  typedef struct packed {
    logic power_on;
    logic core_reset;
    logic sample;
    logic ext_ref;
    logic [4:0] channel;
  } adcc_core_t;
endpackage

// File: rtl/adcc_result_mem.sv
// Result holding store with registered read data
`timescale 1ns/100ps
module adcc_result_mem #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store_q;
  logic [WIDTH-1:0] store_d;
  logic [WIDTH-1:0] rd_q;

  always_comb begin
    store_d = store_q;
    if (wr_en) begin
      store_d = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      store_q <= '0;
      rd_q <= '0;
    end else begin
      store_q <= store_d;
      rd_q <= store_d;
    end
  end

  assign rd_data = rd_q;
endmodule

// File: rtl/adcc_top.sv
// Converter control block with AXI4-Lite register slave
// Notes on behaviour
// (RQ1) Analog enable bit routes pin to converter, kills other functions, runtime changeable.
// (RQ2) Pull-high on a pin is dropped while it is an analog input.
// (RQ3) Analog enable overrides port direction; no need to set input first.
// (RQ4) Reference select bit picks external reference pin or main supply.
// (RQ5) Software programs three-bit divider field before converting.
// (RQ6) Software clears power-off bit before starting a conversion.
// (RQ7) Five-bit channel field split over both control registers picks channel.
// (RQ8) Interrupt delivered only with global and converter enables both high.
// (RQ9) Start bit low-high-low begins a conversion.
// (RQ10) Software keeps start bit at zero before the start sequence.
// (RQ11) Pending flag falls at completion; result then readable in two bytes.
// (RQ12) Completion also signalled by converter interrupt when enabled.
// (RQ13) Conversion lasts sixteen selected converter clock periods.
// (RQ14) Conversion runs autonomously; bus stays free meanwhile.
// (RQ15) Power-off bit switches converter circuitry off entirely.
// (RQ16) Result is 12-bit unsigned, all-ones at full scale.
// (RQ17) One step equals reference divided by 4096 codes.
// (RQ18) Start held high keeps converter in reset, pending flag high.
// (RQ19) End of conversion clears pending flag and sets interrupt request.
// (RQ20) Divider codes 0..6 give clock over 1..64; code 7 undefined.
// (RQ21) Software clears interrupt request before enabling it again.
`timescale 1ns/100ps
module adcc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shared pin control
  output logic [adcc_pkg::PIN_COUNT-1:0] pin_analog_sel,
  output logic [adcc_pkg::PIN_COUNT-1:0] pin_pullup_en,
  output logic [adcc_pkg::PIN_COUNT-1:0] pin_output_en,
  // Conversion core
  output adcc_pkg::adcc_core_t core_ctrl,
  input wire logic [adcc_pkg::RES_BITS-1:0] core_code,
  // Interrupt to processor
  output logic conv_irq
);
  localparam int RB = adcc_pkg::RES_BITS;
  localparam int NP = adcc_pkg::PIN_COUNT;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_CONV} adcc_state_t;

  // Divide ratio as a terminal count; code 7 is treated as code 6
  function automatic logic [5:0] div_limit(input logic [2:0] code);
    logic [2:0] c;
    c = (code == adcc_pkg::DIV_UNDEF) ? 3'h6 : code;
    div_limit = 6'((7'h01 << c) - 7'h01);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = r;
  endfunction

  // Register state
  logic [7:0] ctrl0_q, ctrl0_d;
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [NP-1:0] pinen_q, pinen_d;
  logic [NP-1:0] portdir_q, portdir_d;
  logic [NP-1:0] pullup_q, pullup_d;
  logic [1:0] ien_q, ien_d;
  logic req_q, req_d;
  // Bus state
  logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  // Conversion state
  adcc_state_t st_q, st_d;
  logic [5:0] div_q, div_d;
  logic [4:0] per_q, per_d;
  logic pending_q, pending_d;
  logic [4:0] fast_cnt_q, fast_cnt_d;
  logic done;
  logic [RB-1:0] result;

  logic do_write;
  logic start_bit;
  logic tick;
  logic [31:0] wr_word;

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q; // RQ14
  assign do_write = aw_got_q && w_got_q && !bvalid_q;
  assign start_bit = ctrl0_q[adcc_pkg::C0_START];
  assign tick = (div_q == div_limit(ctrl1_q[adcc_pkg::C1_DIV +: 3])); // RQ20

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    pinen_d = pinen_q;
    portdir_d = portdir_q;
    pullup_d = pullup_q;
    ien_d = ien_q;
    req_d = req_q;
    wr_word = 32'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = adcc_pkg::RESP_OKAY;
      case (awaddr_q)
        adcc_pkg::OFS_CTRL0: ctrl0_d = 8'(merge({24'h0, ctrl0_q}, wdata_q, wstrb_q));
        adcc_pkg::OFS_CTRL1: ctrl1_d = 8'(merge({24'h0, ctrl1_q}, wdata_q, wstrb_q));
        adcc_pkg::OFS_PINEN: pinen_d = NP'(merge({20'h0, pinen_q}, wdata_q, wstrb_q)); // RQ1
        adcc_pkg::OFS_PORTDIR: portdir_d = NP'(merge({20'h0, portdir_q}, wdata_q, wstrb_q));
        adcc_pkg::OFS_PULLUP: pullup_d = NP'(merge({20'h0, pullup_q}, wdata_q, wstrb_q));
        adcc_pkg::OFS_INTCTL: begin
          wr_word = merge({29'h0, req_q, ien_q}, wdata_q, wstrb_q);
          ien_d = wr_word[1:0];
          req_d = wr_word[adcc_pkg::IC_REQ];
        end
        adcc_pkg::OFS_RESULT: bresp_d = adcc_pkg::RESP_OKAY;
        default: bresp_d = adcc_pkg::RESP_SLVERR;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (done) req_d = 1'b1; // RQ19
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = adcc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        adcc_pkg::OFS_CTRL0: rdata_d = {24'h0, start_bit, pending_q, ctrl0_q[5:0]};
        adcc_pkg::OFS_CTRL1: rdata_d = {24'h0, ctrl1_q};
        adcc_pkg::OFS_PINEN: rdata_d = {20'h0, pinen_q};
        adcc_pkg::OFS_PORTDIR: rdata_d = {20'h0, portdir_q};
        adcc_pkg::OFS_PULLUP: rdata_d = {20'h0, pullup_q};
        adcc_pkg::OFS_RESULT: rdata_d = {20'h0, result}; // RQ11
        adcc_pkg::OFS_INTCTL: rdata_d = {29'h0, req_q, ien_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = adcc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Conversion sequencer runs beside the bus, never stalling it
  always_comb begin
    st_d = st_q;
    div_d = tick ? 6'h00 : 6'(div_q + 6'h01);
    per_d = per_q;
    pending_d = pending_q;
    done = 1'b0;
    // Converting cycles at the undivided clock; all ones once another divide is seen
    fast_cnt_d = (st_q != ST_CONV) ? 5'h00 : (ctrl1_q[2:0] != 3'h0) ? 5'h1f
        : 5'(fast_cnt_q + {4'h0, fast_cnt_q != 5'h1f});
    case (st_q)
      ST_IDLE: begin
        if (start_bit) begin
          st_d = ST_HOLD;
          pending_d = 1'b1;
        end
      end
      ST_HOLD: begin
        pending_d = 1'b1; // RQ18
        div_d = 6'h00;
        per_d = 5'h00;
        if (!start_bit) begin
          st_d = ST_CONV; // RQ9
        end
      end
      ST_CONV: begin
        if (start_bit) begin
          st_d = ST_HOLD;
        end else if (ctrl0_q[adcc_pkg::C0_POWER_OFF]) begin
          st_d = ST_IDLE;
        end else if (tick) begin
          per_d = 5'(per_q + 5'h01);
          if (per_q == 5'(adcc_pkg::CONV_PERIODS - 1)) begin
            st_d = ST_IDLE; // RQ13
            pending_d = 1'b0; // RQ11
            done = 1'b1; // RQ19
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
      ctrl0_q <= adcc_pkg::CTRL0_RST;
      ctrl1_q <= adcc_pkg::CTRL1_RST;
      pinen_q <= adcc_pkg::PINEN_RST;
      portdir_q <= '1;
      pullup_q <= '0;
      ien_q <= 2'h0;
      req_q <= 1'b0;
      st_q <= ST_IDLE;
      div_q <= 6'h00;
      per_q <= 5'h00;
      pending_q <= 1'b1;
      fast_cnt_q <= 5'h00;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      pinen_q <= pinen_d;
      portdir_q <= portdir_d;
      pullup_q <= pullup_d;
      ien_q <= ien_d;
      req_q <= req_d;
      st_q <= st_d;
      div_q <= div_d;
      per_q <= per_d;
      pending_q <= pending_d;
      fast_cnt_q <= fast_cnt_d;
    end
  end

  // Result sampled only at completion, so a read mid-conversion sees the last code
  adcc_result_mem #(.WIDTH(RB)) u_result (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(done),
    .wr_data(core_code), // RQ16 RQ17
    .rd_data(result)
  );

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pin_analog_sel = pinen_q; // RQ1
  assign pin_pullup_en = pullup_q & ~pinen_q; // RQ2
  // Direction register holds 1 for input
  assign pin_output_en = ~portdir_q & ~pinen_q; // RQ3
  assign core_ctrl.power_on = !ctrl0_q[adcc_pkg::C0_POWER_OFF]; // RQ15
  assign core_ctrl.core_reset = (st_q == ST_HOLD); // RQ18
  assign core_ctrl.sample = (st_q == ST_CONV);
  assign core_ctrl.ext_ref = ctrl1_q[adcc_pkg::C1_REF]; // RQ4
  assign core_ctrl.channel = {ctrl1_q[adcc_pkg::C1_CHHI], ctrl0_q[adcc_pkg::C0_CHLO +: 4]}; // RQ7
  assign conv_irq = req_q && ien_q[adcc_pkg::IC_GLOBAL] && ien_q[adcc_pkg::IC_CONV]; // RQ8 RQ12

  pin_isolate_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ2
    (pin_pullup_en & pinen_q) == '0 && (pin_output_en & pinen_q) == '0)
    else $error("Analog pin still has pull-up or output drive");
  hold_pending_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ18
    st_q == ST_HOLD |-> pending_q && core_ctrl.core_reset)
    else $error("Held start did not keep converter in reset");
  start_seq_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
    st_q == ST_HOLD && !start_bit |=> st_q == ST_CONV)
    else $error("Falling start bit did not begin conversion");
  done_flag_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ19
    done |=> !pending_q && req_q)
    else $error("Completion did not clear pending and set request");
  irq_gate_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ8
    conv_irq |-> ien_q == 2'h3 && req_q)
    else $error("Interrupt raised without both enables");
  fast_len_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ13
    st_q == ST_CONV && fast_cnt_q == 5'h0f && ctrl1_q[2:0] == 3'h0
    && !start_bit && !ctrl0_q[5] |-> done)
    else $error("Undivided conversion did not take sixteen cycles");
  div_tick_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ20
    tick && st_q == ST_CONV && $stable(ctrl1_q) |-> div_q == div_limit(ctrl1_q[2:0]))
    else $error("Divider tick at wrong count");
  power_off_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ15
    ctrl0_q[adcc_pkg::C0_POWER_OFF] |-> !core_ctrl.power_on)
    else $error("Converter powered while off bit set");
  bus_free_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ14
    st_q == ST_CONV && s_axi_arvalid && !rvalid_q |-> s_axi_arready)
    else $error("Bus stalled by conversion");
  chan_map_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ4 RQ7
    core_ctrl.channel[4] == ctrl1_q[4] && core_ctrl.ext_ref == ctrl1_q[3])
    else $error("Channel or reference routing wrong");
endmodule

// File: bench/adcc_core_model.sv
// Behavioural conversion core driven by the control block
`timescale 1ns/100ps
module adcc_core_model (
  // Clock
  input wire logic ref_clk,
  // Control and analog level
  input wire adcc_pkg::adcc_core_t core_ctrl,
  input wire logic [11:0] level,
  // Result code
  output logic [11:0] core_code
);
  logic [11:0] junk_q = 12'h5a5;
  // A dead or held core has no valid code, so show a moving pattern
  always @(posedge ref_clk) junk_q <= ~junk_q ^ 12'h001;
  assign core_code = (core_ctrl.power_on && !core_ctrl.core_reset) ? level : junk_q;
endmodule

// File: bench/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module tb;
  logic ref_clk = 0;
  logic reset = 1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic arvalid = 0;
  logic awready, wready, arready, bvalid, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, last_rd;
  logic [11:0] sel, pu_en, oe, code, pe, pd, pu;
  logic [11:0] level = 12'h000;
  adcc_pkg::adcc_core_t core;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} adcc_exp_t;
  adcc_exp_t rq[$];
  logic [1:0] bq[$];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0, dt, p;
  logic [4:0] ch;
  logic rf;

  always #4 ref_clk = ~ref_clk;

  adcc_top uut (
    .ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .pin_analog_sel(sel), .pin_pullup_en(pu_en), .pin_output_en(oe),
    .core_ctrl(core), .core_code(code), .conv_irq(irq)
  );

  adcc_core_model core_m (.ref_clk(ref_clk), .core_ctrl(core), .level(level), .core_code(code));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got & m, exp & m);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Both answer channels are always ready, so each answer is taken where seen
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rvalid && rq.size() > 0) begin
      chk(32'(rresp), 32'(rq[0].r), 32'h3);
      if (rq[0].m != 0) chk(rdata, rq[0].d, rq[0].m);
      void'(rq.pop_front());
    end
    if (bvalid && bq.size() > 0) chk(32'(bresp), 32'(bq.pop_front()), 32'h3);
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = adcc_pkg::RESP_OKAY);
    logic ad, wd;
    ad = 0;
    wd = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r = adcc_pkg::RESP_OKAY);
    rq.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 0;
    do @(posedge ref_clk); while (!rvalid);
    last_rd = rdata;
  endtask

  initial begin
    void'($urandom(88));
    repeat (10) @(posedge ref_clk);
    reset <= 0;
    rd(adcc_pkg::OFS_CTRL0, 32'(adcc_pkg::CTRL0_RST), 32'hff);
    rd(adcc_pkg::OFS_CTRL1, 32'(adcc_pkg::CTRL1_RST), 32'h1f);
    rd(adcc_pkg::OFS_PINEN, 32'(adcc_pkg::PINEN_RST), 32'hfff);
    rd(adcc_pkg::OFS_INTCTL, 32'h0, 32'h7);
    rd(8'h1c, 32'h0, 32'hffffffff, adcc_pkg::RESP_SLVERR);
    wr(8'h1c, 32'h1, adcc_pkg::RESP_SLVERR);
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      pe = 12'($urandom);
      pd = 12'($urandom);
      pu = 12'($urandom);
      wr(adcc_pkg::OFS_PINEN, 32'(pe));
      wr(adcc_pkg::OFS_PORTDIR, 32'(pd));
      wr(adcc_pkg::OFS_PULLUP, 32'(pu));
      @(posedge ref_clk);
      chk(32'(sel), 32'(pe), 32'hfff);
      chk(32'(pu_en), 32'(pu & ~pe), 32'hfff);
      chk(32'(oe), 32'(~pd & ~pe), 32'hfff);
    end
    $display("test pins done");
    for (int i = 0; i < 4; i++) begin
      ch = 5'($urandom);
      rf = 1'($urandom);
      wr(adcc_pkg::OFS_CTRL1, {27'h0, ch[4], rf, 3'h0});
      wr(adcc_pkg::OFS_CTRL0, {24'h0, 3'h0, 1'b0, ch[3:0]});
      @(posedge ref_clk);
      chk(32'(core.channel), 32'(ch), 32'h1f);
      chk(32'(core.ext_ref), 32'(rf), 32'h1);
      chk(32'(core.power_on), 32'h1, 32'h1);
    end
    $display("test control fields done");
    for (int d = 0; d < 8; d++) begin
      p = 1 << ((d == 7) ? 6 : d);
      level <= 12'($urandom);
      wr(adcc_pkg::OFS_INTCTL, 32'h3);
      wr(adcc_pkg::OFS_CTRL1, 32'(d));
      wr(adcc_pkg::OFS_CTRL0, 32'h80);
      repeat (20) @(posedge ref_clk);
      chk(32'(irq), 32'h0, 32'h1);
      chk(32'({core.core_reset, core.sample}), 32'h2, 32'h3);
      rd(adcc_pkg::OFS_CTRL0, 32'h40, 32'h40);
      wr(adcc_pkg::OFS_CTRL0, 32'h00);
      t0 = cyc;
      rd(adcc_pkg::OFS_CTRL1, 32'(d), 32'h1f);
      chk(32'({core.core_reset, core.sample}), 32'h1, 32'h3);
      while (!irq) @(posedge ref_clk);
      dt = cyc - t0;
      chk(32'(dt >= 15 * p && dt <= 16 * p + 3), 32'h1, 32'h1);
      rd(adcc_pkg::OFS_CTRL0, 32'h0, 32'h40);
      rd(adcc_pkg::OFS_INTCTL, 32'h4, 32'h4);
      rd(adcc_pkg::OFS_RESULT, 32'(level), 32'hfff);
    end
    $display("test conversions done");
    // Request is still set here; only both enables may let it through
    for (int en = 0; en < 4; en++) begin
      wr(adcc_pkg::OFS_INTCTL, 32'(4 + en));
      @(posedge ref_clk);
      chk(32'(irq), 32'(en == 3), 32'h1);
    end
    wr(adcc_pkg::OFS_INTCTL, 32'h3);
    @(posedge ref_clk);
    chk(32'(irq), 32'h0, 32'h1);
    $display("test interrupt gating done");
    wr(adcc_pkg::OFS_CTRL1, 32'h0);
    wr(adcc_pkg::OFS_CTRL0, 32'h80);
    wr(adcc_pkg::OFS_CTRL0, 32'h00);
    wr(adcc_pkg::OFS_CTRL0, 32'h20);
    @(posedge ref_clk);
    chk(32'(core.power_on), 32'h0, 32'h1);
    repeat (30) @(posedge ref_clk);
    chk(32'(irq), 32'h0, 32'h1);
    rd(adcc_pkg::OFS_CTRL0, 32'h60, 32'h60);
    $display("test power off abort done");
    wrap_up();
  end
endmodule
